// [pkg/bgds_pkg.sv]
// Shared constants and types for the bridge gate drive sequencer
package bgds_pkg;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int CLK_PERIOD_NS  = 20;
  localparam int DEAD_MAX_NS    = 6000;
  localparam int CHG_MIN_NS     = 7000;
  localparam int CHG_TIMEOUT_NS = 200000;

  localparam int DEAD_W = 9;
  localparam int CNT_W  = 14;
  localparam int NPH    = 2;
  localparam int NSYNC  = 11;

  // Least times round up, the timeout rounds down
  localparam logic [DEAD_W-1:0] DEAD_MAX_CYC =
    DEAD_W'((DEAD_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0]  CHG_MIN_CYC =
    CNT_W'((CHG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int CHG_TIMEOUT_CYC = CHG_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [DEAD_W-1:0] DEAD_RES_CYC_DEF = 9'h032;

  // ******************************************************************
  // Encodings and reset values
  // ******************************************************************
  localparam logic [1:0]        DTCFG_GND = 2'h0;
  localparam logic [1:0]        DTCFG_VDD = 2'h3;
  localparam logic [DEAD_W-1:0] DEAD_ZERO = 9'h000;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 14'h0000;
  localparam logic [NSYNC-1:0]  SYNC_RST  = 11'h000;

  typedef enum logic {
    BGDS_IDLE   = 1'b0,
    BGDS_CHARGE = 1'b1
  } bgds_chg_t;

  typedef struct packed {
    bgds_chg_t        st;
    logic [CNT_W-1:0] cnt;
  } bgds_phase_t;

  typedef struct packed {
    bgds_phase_t [NPH-1:0] ph;
    logic                  fault;
  } bgds_top_st_t;

  typedef struct packed {
    logic              hi;
    logic              lo;
    logic [DEAD_W-1:0] cnt;
  } bgds_dead_st_t;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
  } bgds_sync_st_t;

endpackage : bgds_pkg

// [verilog/bgds_sync.sv]
// Two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
module bgds_sync (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic [bgds_pkg::NSYNC-1:0] d_i,
  output logic      [bgds_pkg::NSYNC-1:0] q_o
);
  bgds_pkg::bgds_sync_st_t st;
  bgds_pkg::bgds_sync_st_t next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= {bgds_pkg::SYNC_RST, bgds_pkg::SYNC_RST};
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;
endmodule : bgds_sync

// [verilog/bgds_dead.sv]
// Per-phase dead time insertion and high/low lockout
`timescale 1ns/1ps
module bgds_dead (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [bgds_pkg::DEAD_W-1:0] dead_i,
  input  wire logic                        kill_i,
  input  wire logic                        req_high_i,
  input  wire logic                        req_low_i,
  output logic                             high_gate_o,
  output logic                             low_gate_o
);
  bgds_pkg::bgds_dead_st_t st;
  bgds_pkg::bgds_dead_st_t next_st;

  always_comb begin
    next_st = st;
    if (st.cnt != bgds_pkg::DEAD_ZERO) begin
      next_st.cnt = st.cnt - 9'h001;
    end
    // Any turn-off reloads the shared gap counter
    if (st.hi && (!req_high_i || kill_i)) begin
      next_st.hi  = 1'b0;
      next_st.cnt = dead_i;
    end
    if (st.lo && (!req_low_i || kill_i)) begin
      next_st.lo  = 1'b0;
      next_st.cnt = dead_i;
    end
    // A counter already at zero lets the on-command straight through
    if (!kill_i && st.cnt == bgds_pkg::DEAD_ZERO) begin
      if (req_high_i && !req_low_i && !st.lo) begin
        next_st.hi = 1'b1;
      end
      if (req_low_i && !st.hi) begin
        next_st.lo = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= {1'b0, 1'b0, bgds_pkg::DEAD_ZERO};
    end else begin
      st <= next_st;
    end
  end

  assign high_gate_o = st.hi;
  assign low_gate_o  = st.lo;

  a_no_overlap: assert property (@(posedge clk_i) disable iff (rst_i)
    !(st.hi && st.lo))
    else $error("High and low gate on together");

  a_dead_load: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(st.hi) |-> st.cnt == dead_i
      ##1 (!st.lo || $past(st.cnt) == bgds_pkg::DEAD_ZERO))
    else $error("Dead gap not loaded on high turn-off");

  a_comp_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.lo) |-> $past(st.cnt) == bgds_pkg::DEAD_ZERO && !$past(st.hi))
    else $error("Low gate on inside dead gap");

  a_direct_on: assert property (@(posedge clk_i) disable iff (rst_i)
    req_low_i && !kill_i && !st.hi && st.cnt == bgds_pkg::DEAD_ZERO
      |=> st.lo)
    else $error("Low gate delayed with no gap pending");
endmodule : bgds_dead

// [verilog/bgds_top.sv]
// Bridge gate drive sequencer: dead time, braking and bootstrap charging
//
// Behaviour
// - After a switch turns off, its complement waits out the dead time.
// - One dead-time value serves both bridge phases.
// - Config tied to logic supply selects the maximum dead time, 6 us.
// - Config tied to ground applies no internal dead time.
// - Only on-commands inside the gap after a turn-off, or high-side ones while the bootstrap is low or a charge runs, are delayed.
// - With the complement always off, the gate still waits out the gap its own turn-off starts.
// - Both-low or both-high command patterns hold those switches on.
// - Each phase bootstrap voltage is watched independently, while its high side is requested.
// - Bootstrap low while high side on forces a low-side charge.
// - Bootstrap low at high-side request withholds high side, charges first.
// - A charge cycle lasts at least 7 us, longer if needed.
// - No recovery within 200 us ends charging and raises the fault.
// - Both commands high drives only the low-side switch.
// - Bootstrap fault pulls fault low, kills gates, latched until reset.
// - Reset input low holds all gate drives inactive.
`timescale 1ns/1ps
module bgds_top #(
  parameter int CHG_TIMEOUT_CYCLES = bgds_pkg::CHG_TIMEOUT_CYC,
  parameter logic [bgds_pkg::DEAD_W-1:0] DEAD_RES_CYCLES =
    bgds_pkg::DEAD_RES_CYC_DEF
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       phase_a_high_cmd_i,
  input  wire logic       phase_a_low_cmd_i,
  input  wire logic       phase_b_high_cmd_i,
  input  wire logic       phase_b_low_cmd_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] deadtime_config_in_i,
  input  wire logic [1:0] boot_below_uv_i,
  input  wire logic [1:0] boot_above_hys_i,
  output logic      [1:0] high_gate_out_o,
  output logic      [1:0] low_gate_out_o,
  output logic            fault_o,
  output logic            fault_oe_o,
  output logic      [1:0] charging_o
);

  // ******************************************************************
  // Constants
  // ******************************************************************
  localparam int NPH = bgds_pkg::NPH;
  localparam logic [bgds_pkg::CNT_W-1:0] CHG_MIN_LAST =
    bgds_pkg::CHG_MIN_CYC - 14'h0001;
  localparam logic [bgds_pkg::CNT_W-1:0] TO_LAST =
    bgds_pkg::CNT_W'(CHG_TIMEOUT_CYCLES - 1);
  localparam logic [8:0] BRAKE_SETTLE = bgds_pkg::DEAD_MAX_CYC + 9'h003;

  // ******************************************************************
  // Pin synchronisers
  // ******************************************************************
  logic [bgds_pkg::NSYNC-1:0] pins_raw;
  logic [bgds_pkg::NSYNC-1:0] pins_s;
  logic [NPH-1:0]             hi_cmd;
  logic [NPH-1:0]             lo_cmd;
  logic                       rst_n_s;
  logic [1:0]                 dt_cfg;
  logic [NPH-1:0]             boot_below;
  logic [NPH-1:0]             boot_above;

  assign pins_raw = {reset_n_i, deadtime_config_in_i, boot_below_uv_i,
                     boot_above_hys_i, phase_b_high_cmd_i, phase_a_high_cmd_i,
                     phase_b_low_cmd_i, phase_a_low_cmd_i};

  bgds_sync u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pins_raw),
    .q_o   (pins_s)
  );

  assign lo_cmd     = pins_s[1:0];
  assign hi_cmd     = pins_s[3:2];
  assign boot_above = pins_s[5:4];
  assign boot_below = pins_s[7:6];
  assign dt_cfg     = pins_s[9:8];
  assign rst_n_s    = pins_s[10];

  // ******************************************************************
  // Dead time selection
  // ******************************************************************
  // The config pin is a strap; a resistor setting is presented as a fixed
  // cycle count because its analogue value is static in operation.
  logic [bgds_pkg::DEAD_W-1:0] dead_cyc;

  always_comb begin
    case (dt_cfg)
      bgds_pkg::DTCFG_VDD: dead_cyc = bgds_pkg::DEAD_MAX_CYC;
      bgds_pkg::DTCFG_GND: dead_cyc = bgds_pkg::DEAD_ZERO;
      default:             dead_cyc = DEAD_RES_CYCLES;
    endcase
  end

  // ******************************************************************
  // Bootstrap charge sequencing
  // ******************************************************************
  bgds_pkg::bgds_top_st_t st;
  bgds_pkg::bgds_top_st_t next_st;
  logic                   kill;
  logic [NPH-1:0]         want_hi;
  logic [NPH-1:0]         req_hi;
  logic [NPH-1:0]         req_lo;
  logic [NPH-1:0]         chg;

  // Fault or reset pin low removes every gate drive
  assign kill = st.fault || !rst_n_s;

  always_comb begin
    for (int i = 0; i < NPH; i++) begin
      chg[i]     = (st.ph[i].st == bgds_pkg::BGDS_CHARGE);
      want_hi[i] = hi_cmd[i] && !lo_cmd[i];
      // Withheld while the bootstrap is low or a charge runs
      req_hi[i]  = want_hi[i] && !chg[i] && !boot_below[i];
      req_lo[i]  = lo_cmd[i] || chg[i];
    end
  end

  always_comb begin
    next_st = st;
    // Clear first; reset pin low also kills any charge, so no timeout latches that cycle
    if (!rst_n_s) begin
      next_st.fault = 1'b0;
    end
    for (int i = 0; i < NPH; i++) begin
      case (st.ph[i].st)
        bgds_pkg::BGDS_IDLE: begin
          next_st.ph[i].cnt = bgds_pkg::CNT_ZERO;
          if (!kill && want_hi[i] && boot_below[i]) begin
            next_st.ph[i].st = bgds_pkg::BGDS_CHARGE;
          end
        end
        bgds_pkg::BGDS_CHARGE: begin
          next_st.ph[i].cnt = st.ph[i].cnt + 14'h0001;
          if (kill) begin
            next_st.ph[i].st = bgds_pkg::BGDS_IDLE;
          end else if (st.ph[i].cnt >= CHG_MIN_LAST
                       && boot_above[i]) begin
            next_st.ph[i].st = bgds_pkg::BGDS_IDLE;
          end else if (st.ph[i].cnt == TO_LAST) begin
            next_st.ph[i].st = bgds_pkg::BGDS_IDLE;
            next_st.fault    = 1'b1;
          end
        end
        default: begin
          next_st.ph[i].st = bgds_pkg::BGDS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NPH; i++) begin
        st.ph[i].st  <= bgds_pkg::BGDS_IDLE;
        st.ph[i].cnt <= bgds_pkg::CNT_ZERO;
      end
      st.fault <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ******************************************************************
  // Gate drive per phase
  // ******************************************************************
  // The same dead time goes to both phases; there is no per-phase setting.
  for (genvar g = 0; g < NPH; g++) begin : g_phase
    bgds_dead u_dead (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .dead_i      (dead_cyc),
      .kill_i      (kill),
      .req_high_i  (req_hi[g]),
      .req_low_i   (req_lo[g]),
      .high_gate_o (high_gate_out_o[g]),
      .low_gate_o  (low_gate_out_o[g])
    );
  end

  // Open drain: pulls low while the fault is latched
  assign fault_o    = 1'b0;
  assign fault_oe_o = st.fault;
  always_comb begin
    for (int i = 0; i < NPH; i++) begin
      charging_o[i] = st.ph[i].st;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Braking helper: cycles the both-low pattern has stood unkilled
  logic [8:0] brake_cnt;
  logic       brake_lo;
  assign brake_lo = (lo_cmd == 2'h3) && (hi_cmd == 2'h0) && !kill
                    && (chg == 2'h0);
  always_ff @(posedge clk_i) begin
    if (rst_i || !brake_lo) begin
      brake_cnt <= 9'h000;
    end else if (brake_cnt != 9'h1ff) begin
      brake_cnt <= brake_cnt + 9'h001;
    end
  end

  a_brake_low: assert property (
    brake_cnt == BRAKE_SETTLE |-> low_gate_out_o == 2'h3
      && high_gate_out_o == 2'h0)
    else $error("Braking pattern did not hold both low sides on");

  a_dead_vdd: assert property (
    dt_cfg == bgds_pkg::DTCFG_VDD |-> dead_cyc == 9'h12c)
    else $error("Tied-high config not giving maximum dead time");

  a_dead_gnd: assert property (
    dt_cfg == bgds_pkg::DTCFG_GND |-> dead_cyc == 9'h000)
    else $error("Tied-low config not disabling dead time");

  a_fault_kill: assert property (
    fault_oe_o |=> high_gate_out_o == 2'h0 && low_gate_out_o == 2'h0)
    else $error("Gates active with fault latched");

  a_fault_hold: assert property (
    fault_oe_o && rst_n_s |=> fault_oe_o)
    else $error("Fault cleared without reset input");

  a_reset_off: assert property (
    !rst_n_s |=> high_gate_out_o == 2'h0 && low_gate_out_o == 2'h0)
    else $error("Gates active while reset input low");

  for (genvar g = 0; g < NPH; g++) begin : g_chk
    sequence s_start_charge;
      !kill && want_hi[g] && boot_below[g]
        && st.ph[g].st == bgds_pkg::BGDS_IDLE;
    endsequence

    sequence s_timeout;
      chg[g] && st.ph[g].cnt == TO_LAST && !boot_above[g] && !kill;
    endsequence

    a_charge_entry: assert property (
      s_start_charge |-> !req_hi[g] ##1 chg[g] && req_lo[g])
      else $error("Low bootstrap did not start a charge cycle");

    a_high_withheld: assert property (
      chg[g] |-> !req_hi[g] ##1 !$rose(high_gate_out_o[g]))
      else $error("High side driven during charge cycle");

    a_charge_min: assert property (
      $fell(chg[g]) && !$past(kill) |-> $past(st.ph[g].cnt) >= 14'h015d)
      else $error("Charge cycle shorter than minimum");

    a_charge_timeout: assert property (
      s_timeout |=> fault_oe_o && !chg[g] ##1 fault_oe_o || !rst_n_s)
      else $error("Charge timeout did not latch fault");

    a_both_cmd_low: assert property (
      hi_cmd[g] && lo_cmd[g] |-> !req_hi[g] && req_lo[g])
      else $error("Both commands high did not favour low side");
  end

endmodule : bgds_top

// [bench/bgds_ctrl_model.sv]
// Controller model driving the four phase command pins
`timescale 1ns/1ps
module bgds_ctrl_model #(
  parameter int GAP = 4
) (
  input  wire logic       clk_i,
  input  wire logic       space_i,
  input  wire logic [1:0] req_hi_i,
  input  wire logic [1:0] req_lo_i,
  output logic            phase_a_high_cmd_o,
  output logic            phase_a_low_cmd_o,
  output logic            phase_b_high_cmd_o,
  output logic            phase_b_low_cmd_o
);
  logic [1:0] hi_q = 2'h0;
  logic [1:0] lo_q = 2'h0;
  int         gap[2] = '{0, 0};

  // ******************************************************************
  // Pin drive on the falling edge
  // ******************************************************************
  // Both-low or both-high requests pass as given for braking
  always @(negedge clk_i) begin
    for (int p = 0; p < 2; p++) begin
      if (gap[p] > 0) begin
        gap[p]--;
      end else if (space_i && ((req_hi_i[p] && !req_lo_i[p] && lo_q[p]) ||
                               (req_lo_i[p] && !req_hi_i[p] && hi_q[p])))
      begin
        // Own dead gap when the device inserts none
        hi_q[p] <= 1'b0;
        lo_q[p] <= 1'b0;
        gap[p]  = GAP;
      end else begin
        hi_q[p] <= req_hi_i[p];
        lo_q[p] <= req_lo_i[p];
      end
    end
  end

  assign phase_a_high_cmd_o = hi_q[0];
  assign phase_a_low_cmd_o  = lo_q[0];
  assign phase_b_high_cmd_o = hi_q[1];
  assign phase_b_low_cmd_o  = lo_q[1];
endmodule : bgds_ctrl_model

// [bench/bgds_top_bench.sv]
// Self-checking bench for the bridge gate drive sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module bgds_top_bench;
  localparam logic [8:0] DRES = 9'h014;
  localparam int D  = 20;
  localparam int DM = int'(bgds_pkg::DEAD_MAX_CYC);
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       reset_n_i = 1'b1;
  logic       space = 1'b0;
  logic [1:0] rq_hi = 2'h0;
  logic [1:0] rq_lo = 2'h0;
  logic [1:0] cfg = 2'h1;
  logic [1:0] below = 2'h0;
  logic [1:0] above = 2'h3; // Bootstraps start charged
  logic       ah, al, bh, bl, fault_o, fault_oe_o;
  logic [1:0] high_g, low_g, charging_o;
  int         n_fail = 0;
  int         comparisons = 0;
  int         cyc_cnt = 0;

  always #10 clk_i = ~clk_i;

  bgds_ctrl_model u_ctrl (.clk_i(clk_i), .space_i(space), .req_hi_i(rq_hi),
    .req_lo_i(rq_lo), .phase_a_high_cmd_o(ah), .phase_a_low_cmd_o(al),
    .phase_b_high_cmd_o(bh), .phase_b_low_cmd_o(bl));

  bgds_top #(.CHG_TIMEOUT_CYCLES(500), .DEAD_RES_CYCLES(DRES)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .phase_a_high_cmd_i(ah),
    .phase_a_low_cmd_i(al), .phase_b_high_cmd_i(bh),
    .phase_b_low_cmd_i(bl), .reset_n_i(reset_n_i),
    .deadtime_config_in_i(cfg), .boot_below_uv_i(below),
    .boot_above_hys_i(above), .high_gate_out_o(high_g),
    .low_gate_out_o(low_g), .fault_o(fault_o), .fault_oe_o(fault_oe_o),
    .charging_o(charging_o));

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic req(input logic [1:0] h, input logic [1:0] l);
    // Non-blocking so the model, also on this edge, sees a settled value
    @(negedge clk_i);
    rq_hi <= h;
    rq_lo <= l;
  endtask : req

  task automatic conclude;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // Whole sequence needs about 1840 cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt >= 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ******************************************************************
  // Tests
  // ******************************************************************
  initial begin
    cyc(8);
    rst_i = 1'b0;
    `CHK("gates in reset", 4'h0, {high_g, low_g})
    cyc(5);
    req(2'h3, 2'h0);
    cyc(5);
    `CHK("high direct", 2'h3, high_g)
    req(2'h0, 2'h3);
    cyc(D);
    `CHK("low in gap", 2'h0, low_g)
    cyc(6);
    `CHK("low after gap", 2'h3, low_g)
    req(2'h0, 2'h0);
    cyc(D + 10);
    req(2'h3, 2'h0);
    cyc(5);
    `CHK("late on no gap", 2'h3, high_g)
    cfg = 2'h3;
    cyc(5);
    req(2'h0, 2'h3);
    cyc(DM);
    `CHK("low in max gap", 2'h0, low_g)
    cyc(6);
    `CHK("low after max", 2'h3, low_g)
    cfg = 2'h0;
    space = 1'b1;
    cyc(5);
    req(2'h3, 2'h0);
    cyc(12);
    `CHK("no device gap", 2'h3, high_g)
    req(2'h3, 2'h1);
    cyc(6);
    `CHK("both high low", 6'h09, {2'h0, high_g, low_g})
    req(2'h0, 2'h3);
    cyc(12);
    `CHK("brake low", 4'h3, {high_g, low_g})
    req(2'h3, 2'h0);
    cyc(12);
    `CHK("brake high", 4'hc, {high_g, low_g})
    req(2'h0, 2'h0);
    cyc(5);
    below = 2'h1;
    above = 2'h2;
    req(2'h3, 2'h0);
    cyc(10);
    `CHK("charge first", 6'h19, {charging_o, high_g, low_g})
    below = 2'h0;
    above = 2'h3;
    cyc(290);
    `CHK("charge min", 1'b1, charging_o[0])
    cyc(100);
    `CHK("charge done", 6'h0c, {charging_o, high_g, low_g})
    below = 2'h1;
    above = 2'h2;
    cyc(10);
    `CHK("charge at on", 6'h19, {charging_o, high_g, low_g})
    below = 2'h0;
    above = 2'h3;
    cyc(400);
    `CHK("high back", 2'h3, high_g)
    below = 2'h1;
    above = 2'h2;
    cyc(530);
    `CHK("fault set", 6'h20, {fault_oe_o, fault_o, high_g, low_g})
    below = 2'h0;
    above = 2'h3;
    cyc(20);
    `CHK("fault latched", 5'h10, {fault_oe_o, high_g, low_g})
    reset_n_i = 1'b0;
    cyc(6);
    `CHK("fault cleared", 5'h00, {fault_oe_o, high_g, low_g})
    reset_n_i = 1'b1;
    cyc(10);
    `CHK("run again", 2'h3, high_g)
    reset_n_i = 1'b0;
    cyc(6);
    `CHK("reset pin off", 4'h0, {high_g, low_g})
    conclude();
  end
endmodule : bgds_top_bench
